/* verilog/sac_conversion_control.sv */
// control of a 10-bit successive approximation converter
//
// Notes on behaviour
// - input beyond references gives full or zero code
// - completion loads results; 8-bit rounds into low
// - flag sets on transfer; irq needs enable
// - async enable selects dedicated oscillator, runs converting
// - low power bit picks oscillator band
// - both selects low gives alternate clock
// - input select high with async enable low gives bus clock
// - source divided by 1, 2, 4, 8
// - one channel from channel field
// - mode field picks 10-bit or 8-bit
// - control write with channel not all ones starts
// - no hardware trigger; software or continuous only
// - continuous mode restarts after every transfer
// - in 10-bit mode, high read, low unread blocks transfer
// - blocked transfer always starts another conversion
// - control, clock writes, reset, stop without async enable abort
// - abort keeps results; reset clears them
// - single mode powers down after finishing
// - abort or reset enters idle low power
// - long sample bit extends sample window
// - conversion time bounded by clock counts
//
// Local design decisions: the register offsets and the address-and-strobe port.
module sac_conversion_control (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // system
   input wire logic stop_mode,
   input wire logic alt_clock_tick,
   // analog side
   input wire logic async_osc_tick,
   input wire logic comparator_high,
   output logic [4:0] channel_select,
   output logic [9:0] trial_code,
   output logic sample_enable,
   output logic converter_power,
   output logic async_osc_run,
   output logic async_osc_low_band,
   // completion
   output logic conversion_complete_flag,
   output logic complete_irq
);
   import sac_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state

   // all state of the sequencer and register file
   typedef struct packed {
      sac_state_t phase;      // sequencer state
      logic flag;             // conversion complete flag
      logic irq_enable;       // complete_irq_enable
      logic continuous;       // continuous_enable
      logic [4:0] channel;    // channel_select_field
      logic low_power;        // low_power_config
      logic [1:0] divide;     // clock_divide_field
      logic long_sample;      // long_sample_select
      logic [1:0] mode;       // resolution select
      logic input_clk;        // input_clock_select
      logic async_en;         // async_clock_enable
      logic [9:0] result;     // result held for the two result regs
      logic high_read;        // high read, low not yet read
      logic [4:0] sample_cnt; // converter clocks left in sample
      logic [3:0] bit_idx;    // trial bit position
      logic [9:0] trial;      // code under trial
      logic [1:0] settle;     // cycles since trial changed
      logic cmp1;             // comparator synchroniser stage one
      logic cmp2;             // comparator synchroniser stage two
      logic irq;              // interrupt request
      logic [7:0] rdata;      // registered read data
      logic powered;          // converter powered
      logic osc_run;          // oscillator running
      logic sampling;         // sample window open
   } sac_ctl_state_t;

   sac_ctl_state_t state;
   sac_ctl_state_t next_state;

   // control signals of the current cycle
   logic wr_sc;
   logic wr_cc;
   logic rd_high;
   logic rd_low;
   logic ten_bit;
   logic stop_abort;
   logic start;
   logic transfer_ok;
   logic set_flag;
   logic [9:0] final_code;
   logic [7:0] status_view;
   logic [7:0] config_view;

   // divider link
   sac_clk_if clk_link ();

   ////////////////////////////////////////////////////////////////////
   // converter clock

   // divider instance
   sac_clock_divider u_divider (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .async_osc_tick(async_osc_tick),
      .alt_clock_tick(alt_clock_tick),
      .link(clk_link.divider)
   );

   // configuration toward the divider
   assign clk_link.async_enable = state.async_en;
   assign clk_link.input_clock_select = state.input_clk;
   assign clk_link.divide = state.divide;
   assign clk_link.running = state.powered;

   ////////////////////////////////////////////////////////////////////
   // register access decode

   // strobes and register views
   always_comb begin
      wr_sc = reg_write && reg_addr == SAC_OFS_STATUS_CONTROL;
      wr_cc = reg_write && reg_addr == SAC_OFS_CLOCK_CONFIG;
      rd_high = reg_read && reg_addr == SAC_OFS_RESULT_HIGH;
      rd_low = reg_read && reg_addr == SAC_OFS_RESULT_LOW;
      ten_bit = state.mode == SAC_MODE_TEN_BIT;
      stop_abort = stop_mode && !state.async_en;
      // only software starts, no trigger input
      start = wr_sc && reg_wdata[SAC_SC_CHAN_LSB +: 5] != SAC_CHAN_OFF
         && !stop_abort;
      status_view = '0;
      status_view[SAC_SC_FLAG_BIT] = state.flag;
      status_view[SAC_SC_IRQ_EN_BIT] = state.irq_enable;
      status_view[SAC_SC_CONT_BIT] = state.continuous;
      status_view[SAC_SC_CHAN_LSB +: 5] = state.channel;
      config_view = '0;
      config_view[SAC_CC_LOW_POWER_BIT] = state.low_power;
      config_view[SAC_CC_DIV_LSB +: 2] = state.divide;
      config_view[SAC_CC_LONG_SAMPLE_BIT] = state.long_sample;
      config_view[SAC_CC_MODE_LSB +: 2] = state.mode;
      config_view[SAC_CC_INPUT_CLK_BIT] = state.input_clk;
      config_view[SAC_CC_ASYNC_EN_BIT] = state.async_en;
   end

   ////////////////////////////////////////////////////////////////////
   // next state

   // sequencer, result transfer and registers
   always_comb begin
      next_state = state;
      next_state.cmp1 = comparator_high;
      next_state.cmp2 = state.cmp1;
      transfer_ok = 1'b0;
      set_flag = 1'b0;
      // comparator decides each trial, so saturation is natural
      final_code = state.trial;

      // trial age for the synchronised comparator
      if (state.settle != SAC_SETTLE_CYCLES) begin
         next_state.settle = 2'(state.settle + 2'h1);
      end

      unique case (state.phase)
         // nothing running
         SAC_IDLE: begin
            next_state.powered = 1'b0;
         end
         // sample window in converter clocks
         SAC_SAMPLE: begin
            if (clk_link.converter_tick) begin
               if (state.sample_cnt == 5'h01) begin
                  next_state.phase = SAC_CONVERT;
                  next_state.bit_idx = 4'h9;
                  next_state.trial = sac_bit(4'h9);
                  next_state.settle = 2'h0;
               end else begin
                  next_state.sample_cnt = 5'(state.sample_cnt - 5'h01);
               end
            end
         end
         // one trial per converter clock once settled
         SAC_CONVERT: begin
            if (clk_link.converter_tick
               && state.settle == SAC_SETTLE_CYCLES) begin
               next_state.settle = 2'h0;
               // drop the trial bit if the input is below it
               if (!state.cmp2) begin
                  next_state.trial = state.trial & ~sac_bit(state.bit_idx);
               end
               if (state.bit_idx == 4'h0) begin
                  next_state.phase = SAC_TRANSFER;
               end else begin
                  next_state.bit_idx = 4'(state.bit_idx - 4'h1);
                  next_state.trial = next_state.trial
                     | sac_bit(4'(state.bit_idx - 4'h1));
               end
            end
         end
         // move result into the result registers
         SAC_TRANSFER: begin
            // block while high read and low pending
            if (ten_bit && state.high_read) begin
               next_state.phase = SAC_SAMPLE;
            end else begin
               transfer_ok = 1'b1;
               set_flag = 1'b1;
               // full code or rounded 8-bit code
               next_state.result = ten_bit ? final_code
                  : {2'h0, sac_round8(final_code)};
               if (state.continuous) begin
                  next_state.phase = SAC_SAMPLE;
               end else begin
                  next_state.phase = SAC_IDLE;
                  next_state.powered = 1'b0;
                  next_state.trial = '0;
               end
            end
         end
      endcase

      // restart a fresh sample window when re-entering sampling
      if (state.phase == SAC_TRANSFER && next_state.phase == SAC_SAMPLE) begin
         next_state.sample_cnt = state.long_sample ? SAC_SAMPLE_LONG
            : SAC_SAMPLE_SHORT;
         next_state.trial = '0;
      end

      // read side effects on the interlock
      if (rd_high && ten_bit) begin
         next_state.high_read = 1'b1;
      end
      if (rd_low) begin
         next_state.high_read = 1'b0;
      end

      // flag clears on control write or low read
      if (wr_sc || rd_low) begin
         next_state.flag = 1'b0;
         next_state.irq = 1'b0;
      end
      // set wins over a low read clear; irq only if enabled now
      if (set_flag) begin
         next_state.flag = 1'b1;
         next_state.irq = state.irq_enable;
      end

      // clock configuration write
      if (wr_cc) begin
         next_state.low_power = reg_wdata[SAC_CC_LOW_POWER_BIT];
         next_state.divide = reg_wdata[SAC_CC_DIV_LSB +: 2];
         next_state.long_sample = reg_wdata[SAC_CC_LONG_SAMPLE_BIT];
         next_state.mode = reg_wdata[SAC_CC_MODE_LSB +: 2];
         next_state.input_clk = reg_wdata[SAC_CC_INPUT_CLK_BIT];
         next_state.async_en = reg_wdata[SAC_CC_ASYNC_EN_BIT];
      end

      // status and control write
      if (wr_sc) begin
         next_state.irq_enable = reg_wdata[SAC_SC_IRQ_EN_BIT];
         next_state.continuous = reg_wdata[SAC_SC_CONT_BIT];
         // single channel latched from the field
         next_state.channel = reg_wdata[SAC_SC_CHAN_LSB +: 5];
      end

      // abort on either write or on stop without async enable
      // aborts leave the held result untouched
      // abort drops to idle at once
      if (wr_sc || wr_cc || stop_abort) begin
         next_state.phase = SAC_IDLE;
         next_state.powered = 1'b0;
         next_state.trial = '0;
         if (transfer_ok) begin
            next_state.result = state.result;
            next_state.flag = state.flag && !wr_sc;
            next_state.irq = state.irq && !wr_sc;
         end
      end

      // control write with a live channel restarts at once
      if (start) begin
         next_state.phase = SAC_SAMPLE;
         next_state.powered = 1'b1;
         next_state.sample_cnt = state.long_sample ? SAC_SAMPLE_LONG
            : SAC_SAMPLE_SHORT;
      end

      // oscillator runs only while converting with async enable
      next_state.osc_run = next_state.powered && next_state.async_en;
      next_state.sampling = next_state.phase == SAC_SAMPLE;

      // registered read data, one cycle after the strobe
      next_state.rdata = '0;
      if (reg_read) begin
         unique case (reg_addr)
            SAC_OFS_STATUS_CONTROL: next_state.rdata = status_view;
            SAC_OFS_CLOCK_CONFIG: next_state.rdata = config_view;
            SAC_OFS_RESULT_HIGH: next_state.rdata = {6'h00,
               state.result[9:8]};
            SAC_OFS_RESULT_LOW: next_state.rdata = state.result[7:0];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   // reset returns results to reset value
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
         state.phase <= SAC_IDLE;
         state.channel <= SAC_SC_RESET[SAC_SC_CHAN_LSB +: 5];
         state.result <= SAC_RESULT_RESET;
         state.sample_cnt <= SAC_SAMPLE_SHORT;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, each straight from the state register

   // timing follows from sample plus ten trials per conversion
   assign reg_rdata = state.rdata;
   assign channel_select = state.channel;
   assign trial_code = state.trial;
   assign sample_enable = state.sampling;
   assign converter_power = state.powered;
   assign async_osc_run = state.osc_run;
   // oscillator band from low power bit
   assign async_osc_low_band = state.low_power;
   assign conversion_complete_flag = state.flag;
   assign complete_irq = state.irq;

endmodule // sac_conversion_control

/* shared/sac_pkg.sv */
// constants, types and helpers shared by the converter control block
package sac_pkg;

   // register offsets on the plain register port
   localparam logic [1:0] SAC_OFS_STATUS_CONTROL = 2'h0;
   localparam logic [1:0] SAC_OFS_CLOCK_CONFIG = 2'h1;
   localparam logic [1:0] SAC_OFS_RESULT_HIGH = 2'h2;
   localparam logic [1:0] SAC_OFS_RESULT_LOW = 2'h3;

   // status_control_reg field positions
   localparam int SAC_SC_FLAG_BIT = 7;
   localparam int SAC_SC_IRQ_EN_BIT = 6;
   localparam int SAC_SC_CONT_BIT = 5;
   localparam int SAC_SC_CHAN_LSB = 0;

   // clock_config_reg field positions
   localparam int SAC_CC_LOW_POWER_BIT = 7;
   localparam int SAC_CC_DIV_LSB = 5;
   localparam int SAC_CC_LONG_SAMPLE_BIT = 4;
   localparam int SAC_CC_MODE_LSB = 2;
   localparam int SAC_CC_INPUT_CLK_BIT = 1;
   localparam int SAC_CC_ASYNC_EN_BIT = 0;

   // reset values
   localparam logic [7:0] SAC_SC_RESET = 8'h1F;
   localparam logic [7:0] SAC_CC_RESET = 8'h00;
   localparam logic [9:0] SAC_RESULT_RESET = 10'h000;

   // channel field value that starts nothing
   localparam logic [4:0] SAC_CHAN_OFF = 5'h1F;
   // resolution code for 10-bit mode, all others give 8-bit
   localparam logic [1:0] SAC_MODE_TEN_BIT = 2'h1;

   // sample window lengths in converter clocks (3.5 and 23.5 rounded up)
   localparam logic [4:0] SAC_SAMPLE_SHORT = 5'h04;
   localparam logic [4:0] SAC_SAMPLE_LONG = 5'h18;
   // bus clocks a trial must stand before the synced comparator is valid
   localparam logic [1:0] SAC_SETTLE_CYCLES = 2'h3;
   // full scale codes
   localparam logic [9:0] SAC_FULL_TEN = 10'h3FF;
   localparam logic [7:0] SAC_FULL_EIGHT = 8'hFF;

   // conversion sequencer states
   typedef enum logic [1:0] {
      SAC_IDLE = 2'b00,
      SAC_SAMPLE = 2'b01,
      SAC_CONVERT = 2'b10,
      SAC_TRANSFER = 2'b11
   } sac_state_t;

   // round a 10-bit code to 8 bits, saturating at full scale
   function automatic logic [7:0] sac_round8(input logic [9:0] code);
      logic [10:0] sum;
      sum = {1'b0, code} + 11'h002;
      sac_round8 = sum[10] ? SAC_FULL_EIGHT : sum[9:2];
   endfunction

   // one-hot trial bit for a position
   function automatic logic [9:0] sac_bit(input logic [3:0] idx);
      sac_bit = 10'h001 << idx;
   endfunction

endpackage

/* shared/sac_clk_if.sv */
// link between the sequencer and the converter clock divider
interface sac_clk_if;
   logic async_enable;       // dedicated oscillator selected
   logic input_clock_select; // bus clock when high, alternate when low
   logic [1:0] divide;       // divide code 1, 2, 4, 8
   logic running;            // conversion in progress
   logic converter_tick;     // one pulse per converter clock
   modport divider (input async_enable, input input_clock_select,
      input divide, input running, output converter_tick);
   modport sequencer (output async_enable, output input_clock_select,
      output divide, output running, input converter_tick);
endinterface

/* verilog/sac_clock_divider.sv */
// converter clock source select and divider
module sac_clock_divider (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic clk_en,
   // source ticks
   input wire logic async_osc_tick,
   input wire logic alt_clock_tick,
   // sequencer side
   sac_clk_if.divider link
);
   import sac_pkg::*;

   // all state of the divider
   typedef struct packed {
      logic sync1;       // first synchroniser stage
      logic sync2;       // second synchroniser stage
      logic sync_last;   // previous second stage, for edge detect
      logic [2:0] count; // source ticks since last output tick
      logic tick;        // converter clock pulse
   } sac_div_state_t;

   sac_div_state_t state;
   sac_div_state_t next_state;
   logic src_tick;
   logic [2:0] ratio_last;

   // next state: pick source, count, pulse
   always_comb begin
      next_state = state;
      next_state.sync1 = async_osc_tick;
      next_state.sync2 = state.sync1;
      next_state.sync_last = state.sync2;
      next_state.tick = 1'b0;
      if (link.async_enable) begin
         src_tick = state.sync2 & ~state.sync_last;
      end else if (link.input_clock_select) begin
         src_tick = 1'b1;
      end else begin
         src_tick = alt_clock_tick;
      end
      // divide by 1, 2, 4 or 8
      ratio_last = 3'((4'h1 << link.divide) - 4'h1);
      if (!link.running) begin
         next_state.count = 3'h0;
      end else if (src_tick) begin
         if (state.count == ratio_last) begin
            next_state.count = 3'h0;
            next_state.tick = 1'b1;
         end else begin
            next_state.count = 3'(state.count + 3'h1);
         end
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   assign link.converter_tick = state.tick;

endmodule // sac_clock_divider

/* dv/sac_conversion_control_props.sv */
// assertion checker for the converter control block
module sac_conversion_control_props
   import sac_pkg::*;
(
   // clock, reset, enable
   input logic clk,
   input logic reset,
   input logic clk_en,
   // register port
   input logic [1:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_write,
   input logic reg_read,
   input logic [7:0] reg_rdata,
   // system and analog side
   input logic stop_mode,
   input logic [4:0] channel_select,
   input logic [9:0] trial_code,
   input logic sample_enable,
   input logic converter_power,
   input logic async_osc_run,
   // completion
   input logic conversion_complete_flag,
   input logic complete_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////
   // accepted writes to the two control registers
   wire logic sc_wr = reg_write && clk_en &&
      reg_addr == SAC_OFS_STATUS_CONTROL;
   wire logic cc_wr = reg_write && clk_en && reg_addr == SAC_OFS_CLOCK_CONFIG;
   ////////////////////////////////////////////////////////////////////////////
   // idle dac quiet
   idle_trial_zero_a: assert property (
      !converter_power |-> trial_code == 10'h000)
      else $error("trial code not zero while idle");
   sample_needs_power_a: assert property (
      sample_enable |-> converter_power)
      else $error("sampling while powered down");
   rdata_idle_a: assert property (
      !$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   high_bits_a: assert property (
      reg_read && reg_addr == SAC_OFS_RESULT_HIGH |=> reg_rdata[7:2] == 6'h00)
      else $error("upper result bits not zero");
   flag_on_transfer_a: assert property (
      $rose(conversion_complete_flag) |-> $past(converter_power))
      else $error("flag set without a conversion");
   irq_with_flag_a: assert property (
      $rose(complete_irq) |-> $rose(conversion_complete_flag))
      else $error("irq raised apart from flag");
   clock_write_abort_a: assert property (
      cc_wr |=> !converter_power)
      else $error("clock write did not abort");
   start_write_a: assert property (
      sc_wr && reg_wdata[4:0] != SAC_CHAN_OFF && !stop_mode |=>
      converter_power && sample_enable &&
      channel_select == $past(reg_wdata[4:0]))
      else $error("control write did not start on channel");
   chan_off_idle_a: assert property (
      sc_wr && reg_wdata[4:0] == SAC_CHAN_OFF |=>
      !converter_power && channel_select == SAC_CHAN_OFF)
      else $error("off channel still converting");
   write_clears_flag_a: assert property (
      sc_wr |=> !conversion_complete_flag)
      else $error("flag survived control write");
   stop_abort_a: assert property (
      stop_mode && converter_power && !async_osc_run |=> !converter_power)
      else $error("stop did not abort conversion");
   osc_run_a: assert property (
      async_osc_run |-> converter_power)
      else $error("oscillator running while idle");
   sample_window_a: assert property (
      $fell(sample_enable) && converter_power |-> $past(sample_enable, 4))
      else $error("sample window too short");
   // main scenarios reached
   cover property ($rose(conversion_complete_flag));
   cover property ($rose(complete_irq));
   cover property (stop_mode && async_osc_run);
endmodule // sac_conversion_control_props

/* dv/tb_sac_conversion_control.sv */
// self-checking bench for the converter control block
module tb_sac_conversion_control;
   timeunit 1ns;
   timeprecision 1ns;
   import sac_pkg::*;
   // design inputs and outputs
   logic clk, reset, clk_en, reg_write, reg_read, stop_mode;
   logic alt_clock_tick, async_osc_tick, comparator_high;
   logic [1:0] reg_addr, div;
   logic [7:0] reg_wdata, reg_rdata;
   logic [4:0] channel_select;
   logic [9:0] trial_code;
   logic sample_enable, converter_power, async_osc_run, async_osc_low_band;
   logic conversion_complete_flag, complete_irq;
   logic [10:0] vin; // analog input level, above 3FF is beyond reference
   int mismatches = 0;
   int n_compared = 0;
   sac_conversion_control dut (.*);
   ////////////////////////////////////////////////////////////////////////////
   // clock, comparator model and source ticks
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      div <= div + 2'h1;
      alt_clock_tick <= div[0];
      async_osc_tick <= div[1] && async_osc_run;
      comparator_high <= vin >= {1'b0, trial_code};
   end
   // hang guard
   initial begin
      #1000000;
      mismatches++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // register port cycles
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // bounded wait for the completion flag
   task automatic wait_flag(output int n);
      n = 0;
      while (conversion_complete_flag !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #1 n++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // reset values of registers and outputs
   task automatic t_regs();
      logic [7:0] d;
      rd(SAC_OFS_STATUS_CONTROL, d);
      chk(d, SAC_SC_RESET);
      rd(SAC_OFS_CLOCK_CONFIG, d);
      chk(d, SAC_CC_RESET);
      rd(SAC_OFS_RESULT_HIGH, d);
      chk(d, 8'h00);
      rd(SAC_OFS_RESULT_LOW, d);
      chk(d, 8'h00);
      chk({channel_select, converter_power}, {SAC_CHAN_OFF, 1'b0});
      $display("test regs done");
   endtask
   // one single conversion judged against the ideal code
   task automatic conv(input logic [7:0] cfg, input logic [7:0] sc,
         input logic [10:0] v, output int n);
      logic [7:0] d;
      logic [9:0] c;
      logic [10:0] r;
      logic ten;
      vin = v;
      c = (v > 11'h3FF) ? 10'h3FF : v[9:0];
      r = ({1'b0, c} + 11'h002) >> 2;
      if (r > 11'h0FF) r = 11'h0FF;
      ten = cfg[3:2] == SAC_MODE_TEN_BIT;
      wr(SAC_OFS_CLOCK_CONFIG, cfg);
      wr(SAC_OFS_STATUS_CONTROL, sc);
      #1 chk(converter_power, 1'b1);
      chk(async_osc_run, cfg[0]);
      if (cfg[0]) chk(async_osc_low_band, cfg[7]);
      wait_flag(n);
      chk(conversion_complete_flag, 1'b1);
      chk(complete_irq, sc[6]);
      chk(channel_select, sc[4:0]);
      chk(converter_power, 1'b0);
      rd(SAC_OFS_RESULT_HIGH, d);
      chk(d, ten ? {6'h00, c[9:8]} : 8'h00);
      rd(SAC_OFS_RESULT_LOW, d);
      chk(d, ten ? c[7:0] : r[7:0]);
      chk(conversion_complete_flag, 1'b0);
   endtask
   // clock sources, dividers, modes and edge codes
   task automatic t_codes();
      logic [7:0] cfgs [8] = '{8'h06, 8'h04, 8'h06, 8'h66,
         8'h02, 8'h72, 8'h81, 8'h0C};
      logic [10:0] vins [8] = '{11'h000, 11'h155, 11'h3FF, 11'h500,
         11'h155, 11'h3FE, 11'h600, 11'h2AA};
      int ns [8];
      for (int i = 0; i < 8; i++) begin
         conv(cfgs[i], {1'b0, i[0], 1'b0, i[4:0]}, vins[i], ns[i]);
      end
      chk(ns[3] > 2 * ns[2], 1'b1);
      chk(ns[5] <= 38 * 8 + 3, 1'b1);
      $display("test codes done");
   endtask
   // high read mid conversion blocks transfer and restarts
   task automatic t_block();
      logic [7:0] d;
      logic seen;
      int n;
      seen = 1'b0;
      vin = 11'h123;
      wr(SAC_OFS_CLOCK_CONFIG, 8'h06);
      wr(SAC_OFS_STATUS_CONTROL, 8'h03);
      rd(SAC_OFS_RESULT_HIGH, d);
      repeat (200) begin
         @(posedge clk);
         #1 seen = seen | conversion_complete_flag;
      end
      chk(seen, 1'b0);
      chk(converter_power, 1'b1);
      rd(SAC_OFS_RESULT_LOW, d);
      chk(d, 8'hAB);
      wait_flag(n);
      rd(SAC_OFS_RESULT_HIGH, d);
      chk(d, 8'h01);
      rd(SAC_OFS_RESULT_LOW, d);
      chk(d, 8'h23);
      $display("test block done");
   endtask
   // continuous restart, then clock write, control write and stop aborts
   task automatic t_abort();
      logic [7:0] d;
      int n;
      vin = 11'h0F0;
      wr(SAC_OFS_STATUS_CONTROL, 8'h22);
      wait_flag(n);
      rd(SAC_OFS_RESULT_LOW, d);
      chk(d, 8'hF0);
      wait_flag(n);
      chk({conversion_complete_flag, converter_power}, 2'h3);
      rd(SAC_OFS_RESULT_LOW, d);
      vin = 11'h00F;
      wr(SAC_OFS_CLOCK_CONFIG, 8'h06);
      #1 chk(converter_power, 1'b0);
      wr(SAC_OFS_STATUS_CONTROL, 8'h02);
      repeat (10) @(posedge clk);
      wr(SAC_OFS_STATUS_CONTROL, 8'h1F);
      #1 chk({channel_select, converter_power}, {SAC_CHAN_OFF, 1'b0});
      wr(SAC_OFS_STATUS_CONTROL, 8'h02);
      stop_mode <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk(converter_power, 1'b0);
      stop_mode <= 1'b0;
      repeat (100) @(posedge clk);
      #1 chk(conversion_complete_flag, 1'b0);
      rd(SAC_OFS_RESULT_LOW, d);
      chk(d, 8'hF0);
      $display("test abort done");
   endtask
   // oscillator keeps converting through stop
   task automatic t_async_stop();
      logic [7:0] d;
      int n;
      vin = 11'h100;
      wr(SAC_OFS_CLOCK_CONFIG, 8'h01);
      wr(SAC_OFS_STATUS_CONTROL, 8'h02);
      stop_mode <= 1'b1;
      wait_flag(n);
      stop_mode <= 1'b0;
      chk(conversion_complete_flag, 1'b1);
      rd(SAC_OFS_RESULT_LOW, d);
      chk(d, 8'h40);
      $display("test async stop done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      reset = 1'b1;
      clk_en = 1'b1;
      {reg_write, reg_read, stop_mode, alt_clock_tick} = 4'h0;
      {async_osc_tick, comparator_high} = 2'h0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      vin = 11'h000;
      div = 2'h0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_codes();
      t_block();
      t_abort();
      t_async_stop();
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      tally_and_finish();
   end
endmodule // tb_sac_conversion_control

bind sac_conversion_control sac_conversion_control_props props (.*);
